// >>> verilog/gpio_port_top.sv
`timescale 1ns/1ps
`include "gpio_port_cfg.svh"
// Behaviour
// - one pull-up enable bit per port 0..5; 1 enables on-chip pull-up
// - enabled pull-up acts only on pins whose direction is input
// - output-mode pins never get the pull-up, whatever the enable bit
// - pins driven by an alternate peripheral output get no pull-up
// - reset clears the pull-up enable register to zero
// - pull-up enable writable as a whole byte or one bit at a time
// - input-direction pins have their output buffer off
// - in output mode a port write updates the latch, pins show it
// - latch holds its value until written again
// - in input mode a port write still updates the latch only
// - reading an output-mode pin returns the latch, latch unchanged
// - reading an input-mode pin returns the pin level, latch unchanged
// - arithmetic on output pins works on latch; result latched, driven
// - arithmetic on input pins may leave latch undefined; pin unaffected
// - single-bit operations access the whole 8-bit port
// - per-pin direction register per port, all ones after reset

module gpio_port_top
#(
    parameter int          ADDR_W    = 18,
    parameter logic [23:0] PORT_PINS = {4'd4, 4'd8, 4'd3, 4'd3,
                                        4'd8, 4'd8}
)
(
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic [ADDR_W-1:0]         awaddr,
    input  wire logic                      awvalid,
    output logic                           awready,
    input  wire logic [31:0]               wdata,
    input  wire logic [3:0]                wstrb,
    input  wire logic                      wvalid,
    output logic                           wready,
    output gpio_port_pkg::axi_resp_t       bresp,
    output logic                           bvalid,
    input  wire logic                      bready,
    input  wire logic [ADDR_W-1:0]         araddr,
    input  wire logic                      arvalid,
    output logic                           arready,
    output logic [31:0]                    rdata,
    output gpio_port_pkg::axi_resp_t       rresp,
    output logic                           rvalid,
    input  wire logic                      rready,
    input  wire logic [8*`NUM_PORTS-1:0]   pin_in,
    input  wire logic [8*`NUM_PORTS-1:0]   alt_out_en,
    input  wire logic [8*`NUM_PORTS-1:0]   alt_out_data,
    output logic [8*`NUM_PORTS-1:0]        pin_out,
    output logic [8*`NUM_PORTS-1:0]        pin_oe,
    output logic [8*`NUM_PORTS-1:0]        pin_pullup
);
    import gpio_port_pkg::*;

    localparam int NP = `NUM_PORTS;

    logic              aw_held_q;
    logic              w_held_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0]       w_data_q;
    logic [3:0]        w_strb_q;
    logic              aw_fire;
    logic              w_fire;
    logic              ar_fire;
    logic              wr_go;
    logic              bvalid_d;
    logic              rvalid_d;
    logic [5:0]        pullup_q;
    logic [7:0]        latch [NP];
    logic [7:0]        mode [NP];
    logic [7:0]        rd_val [NP];
    logic [8*NP-1:0]   latch_flat;
    logic [8*NP-1:0]   mode_flat;
    logic [8*NP-1:0]   pu_flat;
    logic [8*NP-1:0]   mask_flat;

    // write path: address and data are taken in either order
    assign aw_fire  = awvalid & awready;
    assign w_fire   = wvalid & wready;
    assign wr_go    = aw_held_q & w_held_q & ~bvalid;
    assign bvalid_d = wr_go | (bvalid & ~bready);

    // address and data holding; ready drops until the answer is taken
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awready   <= 1'b0;
            wready    <= 1'b0;
            aw_addr_q <= '0;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
        end
        else
        begin
            if (aw_fire)
                aw_addr_q <= awaddr;
            if (w_fire)
            begin
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
            aw_held_q <= (aw_held_q | aw_fire) & ~wr_go;
            w_held_q  <= (w_held_q | w_fire) & ~wr_go;
            awready   <= ~((aw_held_q | aw_fire) & ~wr_go) & ~bvalid_d;
            wready    <= ~((w_held_q | w_fire) & ~wr_go) & ~bvalid_d;
        end
    end

    // write decode
    logic [15:0]     wr_idx;
    logic [NP-1:0]   data_hit;
    logic [NP-1:0]   mode_hit;
    logic            rmw_hit;
    logic            pu_hit;
    logic            pubit_hit;
    logic            wr_err;
    logic            wr_en;
    logic [2:0]      rmw_port;
    logic [2:0]      rmw_bit;
    rmw_op_t         rmw_op;
    logic [7:0]      rmw_opnd;
    logic [7:0]      rmw_cur;
    logic [7:0]      rmw_new;
    logic [7:0]      wr_byte;
    logic [NP-1:0]   latch_we;
    logic [NP-1:0]   mode_we;
    logic [2:0]      pubit_sel;

    assign wr_idx    = aw_addr_q[ADDR_W-1:2];
    assign rmw_port  = w_data_q[`RMW_PORT_LSB +: 3];
    assign rmw_bit   = w_data_q[`RMW_BIT_LSB +: 3];
    assign rmw_op    = rmw_op_t'(w_data_q[`RMW_OP_LSB +: 2]);
    assign rmw_opnd  = w_data_q[`RMW_OPND_LSB +: 8];
    assign pubit_sel = w_data_q[`PUBIT_SEL_LSB +: 3];
    // only the byte lane 0 strobe gates register writes
    assign wr_en     = wr_go & w_strb_q[0];

    // address decode of the held write
    always_comb
    begin
        data_hit  = '0;
        mode_hit  = '0;
        rmw_hit   = 1'b0;
        pu_hit    = 1'b0;
        pubit_hit = 1'b0;
        wr_err    = 1'b0;
        for (int m = 0; m < NP; m++)
        begin
            data_hit[m] = wr_idx == (`PORT_DATA_IDX + 16'(m));
            mode_hit[m] = wr_idx == (`PORT_MODE_IDX + 16'(m));
        end
        if (|data_hit || |mode_hit)
            wr_err = 1'b0;
        else if (wr_idx == `PULLUP_EN_IDX)
            pu_hit = 1'b1;
        else if (wr_idx == `PULLUP_BIT_IDX && pubit_sel < 3'(NP))
            pubit_hit = 1'b1;
        else if (wr_idx == `PORT_RMW_IDX && rmw_port < 3'(NP))
            rmw_hit = 1'b1;
        else
            wr_err = 1'b1;
    end

    // whole-port read-modify-write; inputs contribute their pin level,
    // so untouched input latches take whatever the pin showed
    always_comb
    begin
        rmw_cur = 8'h00;
        for (int m = 0; m < NP; m++)
            if (rmw_port == 3'(m))
                rmw_cur = rd_val[m];
        case (rmw_op)
            OP_BIT_CLR: rmw_new = rmw_cur & ~(8'h01 << rmw_bit);
            OP_BIT_SET: rmw_new = rmw_cur | (8'h01 << rmw_bit);
            OP_ADD:     rmw_new = rmw_cur + rmw_opnd;
            default:    rmw_new = rmw_cur ^ rmw_opnd;
        endcase
        wr_byte = rmw_hit ? rmw_new : w_data_q[7:0];
        for (int m = 0; m < NP; m++)
        begin
            latch_we[m] = wr_en & (data_hit[m] |
                          (rmw_hit & rmw_port == 3'(m)));
            mode_we[m]  = wr_en & mode_hit[m];
        end
    end

    // write answer: unmapped offsets report a slave error
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid <= 1'b0;
            bresp  <= `RESP_OKAY;
        end
        else
        begin
            bvalid <= bvalid_d;
            if (wr_go)
                bresp <= wr_err ? `RESP_SLVERR : `RESP_OKAY;
        end
    end

    // pull-up enables, byte or single-bit access
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            pullup_q <= `PULLUP_RST;
        else if (wr_en & pu_hit)
            pullup_q <= w_data_q[5:0];
        else if (wr_en & pubit_hit)
            pullup_q[pubit_sel] <= w_data_q[`PUBIT_VAL_POS];
    end

    // read path: one read at a time, data registered
    logic [15:0] rd_idx;
    logic [31:0] rd_word;
    logic        rd_err;

    assign ar_fire  = arvalid & arready;
    assign rvalid_d = ar_fire | (rvalid & ~rready);
    assign rd_idx   = araddr[ADDR_W-1:2];

    // reads have no side effect on any latch
    always_comb
    begin
        rd_word = 32'h0000_0000;
        rd_err  = 1'b0;
        if (rd_idx >= `PORT_DATA_IDX && rd_idx < `PORT_DATA_IDX + 16'(NP))
        begin
            for (int m = 0; m < NP; m++)
                if (rd_idx == `PORT_DATA_IDX + 16'(m))
                    rd_word = {24'h0, rd_val[m]};
        end
        else if (rd_idx >= `PORT_MODE_IDX &&
                 rd_idx < `PORT_MODE_IDX + 16'(NP))
        begin
            for (int m = 0; m < NP; m++)
                if (rd_idx == `PORT_MODE_IDX + 16'(m))
                    rd_word = {24'h0, mode[m]};
        end
        else if (rd_idx == `PULLUP_EN_IDX)
            rd_word = {26'h0, pullup_q};
        else if (rd_idx == `PULLUP_BIT_IDX || rd_idx == `PORT_RMW_IDX)
            rd_word = 32'h0000_0000; // command words read as zero
        else
            rd_err = 1'b1;
    end

    // read answer
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= `RESP_OKAY;
        end
        else
        begin
            arready <= ~rvalid_d;
            rvalid  <= rvalid_d;
            if (ar_fire)
            begin
                rdata <= rd_word;
                rresp <= rd_err ? `RESP_SLVERR : `RESP_OKAY;
            end
        end
    end

    // one latch/direction slice and one pad stage per port
    for (genvar m = 0; m < NP; m++)
    begin : g_port
        localparam int         PINS = int'(PORT_PINS[4*m +: 4]);
        localparam logic [7:0] MASK = 8'((9'h001 << PINS) - 9'h001);

        port_slice #(.MASK(MASK)) u_slice (
            .aclk     (aclk),
            .aresetn  (aresetn),
            .latch_we (latch_we[m]),
            .mode_we  (mode_we[m]),
            .wdata    (wr_byte),
            .pin_in   (pin_in[8*m +: 8]),
            .latch_q  (latch[m]),
            .mode_q   (mode[m]),
            .read_val (rd_val[m])
        );

        pad_drive #(.MASK(MASK)) u_pad (
            .aclk      (aclk),
            .aresetn   (aresetn),
            .latch     (latch[m]),
            .mode      (mode[m]),
            .pu_en     (pullup_q[m]),
            .alt_en    (alt_out_en[8*m +: 8]),
            .alt_data  (alt_out_data[8*m +: 8]),
            .pin_out_q (pin_out[8*m +: 8]),
            .pin_oe_q  (pin_oe[8*m +: 8]),
            .pin_pu_q  (pin_pullup[8*m +: 8])
        );

        assign latch_flat[8*m +: 8] = latch[m];
        assign mode_flat[8*m +: 8]  = mode[m] & MASK;
        assign pu_flat[8*m +: 8]    = {8{pullup_q[m]}} & MASK;
        assign mask_flat[8*m +: 8]  = MASK;
    end

    property p_pu_reset;
        @(posedge aclk) disable iff (!aresetn)
        $past(!aresetn) |-> pullup_q == `PULLUP_RST;
    endproperty
    a_pu_reset: assert property (p_pu_reset)
        else $error("pull-up enables not cleared by reset");

    property p_pu_gate;
        @(posedge aclk) disable iff (!aresetn)
        $past(aresetn) |->
            pin_pullup == $past(pu_flat & mode_flat & ~alt_out_en);
    endproperty
    a_pu_gate: assert property (p_pu_gate)
        else $error("pull-up not gated by enable, direction and alt use");

    property p_pu_not_out;
        @(posedge aclk) disable iff (!aresetn)
        (pin_pullup & pin_oe) == '0;
    endproperty
    a_pu_not_out: assert property (p_pu_not_out)
        else $error("pull-up on a driven pin");

    property p_pu_alt;
        @(posedge aclk) disable iff (!aresetn)
        $past(aresetn) |-> (pin_pullup & $past(alt_out_en)) == '0;
    endproperty
    a_pu_alt: assert property (p_pu_alt)
        else $error("pull-up on a pin used by a peripheral output");

    property p_oe_dir;
        @(posedge aclk) disable iff (!aresetn)
        $past(aresetn) |-> pin_oe == $past(~mode_flat & mask_flat);
    endproperty
    a_oe_dir: assert property (p_oe_dir)
        else $error("buffer enable does not follow direction");

    property p_buf_off;
        @(posedge aclk) disable iff (!aresetn)
        (pin_oe & $past(mode_flat)) == '0;
    endproperty
    a_buf_off: assert property (p_buf_off)
        else $error("input pin has its buffer on");

    property p_drive_latch;
        @(posedge aclk) disable iff (!aresetn)
        $past(aresetn) |-> (pin_out & $past(~alt_out_en & ~mode_flat))
            == $past(latch_flat & ~alt_out_en & ~mode_flat);
    endproperty
    a_drive_latch: assert property (p_drive_latch)
        else $error("output pin does not show the latch");

    property p_port_write;
        @(posedge aclk) disable iff (!aresetn)
        (wr_en && data_hit[0]) |=> latch[0] == $past(w_data_q[7:0]);
    endproperty
    a_port_write: assert property (p_port_write)
        else $error("port write did not reach the latch");

    property p_port_read;
        @(posedge aclk) disable iff (!aresetn)
        (ar_fire && rd_idx == `PORT_DATA_IDX) |=>
            rdata[7:0] == $past((mode[0] & pin_in[7:0]) |
                                (~mode[0] & latch[0]));
    endproperty
    a_port_read: assert property (p_port_read)
        else $error("port read returned wrong source");

    property p_rmw_add;
        @(posedge aclk) disable iff (!aresetn)
        (wr_en && rmw_hit && rmw_op == OP_ADD && rmw_port == 3'd1) |=>
            latch[1] == $past(rd_val[1] + rmw_opnd);
    endproperty
    a_rmw_add: assert property (p_rmw_add)
        else $error("arithmetic result not written to latch");

    property p_pu_bit;
        @(posedge aclk) disable iff (!aresetn)
        (wr_en && pubit_hit) |=>
            pullup_q[$past(pubit_sel)] == $past(w_data_q[`PUBIT_VAL_POS]);
    endproperty
    a_pu_bit: assert property (p_pu_bit)
        else $error("single-bit pull-up write lost");

endmodule

// >>> verilog/gpio_port_cfg.svh
`ifndef GPIO_PORT_CFG_SVH
`define GPIO_PORT_CFG_SVH

// register indices; byte address is four times the index
`define PORT_DATA_IDX   16'hFF00
`define PORT_RMW_IDX    16'hFF10
`define PORT_MODE_IDX   16'hFF20
`define PULLUP_EN_IDX   16'hFFF7
`define PULLUP_BIT_IDX  16'hFFF8

`define NUM_PORTS       6

// reset values
`define PULLUP_RST      6'h00
`define MODE_RST        8'hFF
`define LATCH_RST       8'h00

// field positions of the read-modify-write command word
`define RMW_OPND_LSB    0
`define RMW_BIT_LSB     8
`define RMW_OP_LSB      11
`define RMW_PORT_LSB    13

// field positions of the pull-up single-bit command word
`define PUBIT_SEL_LSB   0
`define PUBIT_VAL_POS   8

// bus answers
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// >>> verilog/gpio_port_pkg.sv
package gpio_port_pkg;

    // bus response code
    typedef logic [1:0] axi_resp_t;

    // read-modify-write operations on a whole port
    typedef enum logic [1:0] {
        OP_BIT_CLR,
        OP_BIT_SET,
        OP_ADD,
        OP_XOR
    } rmw_op_t;

endpackage

// >>> verilog/port_slice.sv
`timescale 1ns/1ps
`include "gpio_port_cfg.svh"

module port_slice
#(
    parameter logic [7:0] MASK = 8'hFF
)
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       latch_we,
    input  wire logic       mode_we,
    input  wire logic [7:0] wdata,
    input  wire logic [7:0] pin_in,
    output logic      [7:0] latch_q,
    output logic      [7:0] mode_q,
    output logic      [7:0] read_val
);

    // output latch: written regardless of direction, held otherwise
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            latch_q <= `LATCH_RST & MASK;
        else if (latch_we)
            latch_q <= wdata & MASK;
    end

    // direction: 1 is input; missing pins stay fixed at 1
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            mode_q <= `MODE_RST;
        else if (mode_we)
            mode_q <= wdata | ~MASK;
    end

    // inputs show the pin, outputs show the latch
    assign read_val = ((mode_q & pin_in) | (~mode_q & latch_q)) & MASK;

    property p_latch_hold;
        @(posedge aclk) disable iff (!aresetn)
        !latch_we |=> latch_q == $past(latch_q);
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("latch changed without a write");

    property p_mode_reset;
        @(posedge aclk) disable iff (!aresetn)
        $past(!aresetn) |-> mode_q == `MODE_RST;
    endproperty
    a_mode_reset: assert property (p_mode_reset)
        else $error("direction not all inputs after reset");

endmodule

// >>> verilog/pad_drive.sv
`timescale 1ns/1ps

module pad_drive
#(
    parameter logic [7:0] MASK = 8'hFF
)
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [7:0] latch,
    input  wire logic [7:0] mode,
    input  wire logic       pu_en,
    input  wire logic [7:0] alt_en,
    input  wire logic [7:0] alt_data,
    output logic      [7:0] pin_out_q,
    output logic      [7:0] pin_oe_q,
    output logic      [7:0] pin_pu_q
);

    // pad controls registered so the pins never see decode glitches
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_out_q <= 8'h00;
            pin_oe_q  <= 8'h00;
            pin_pu_q  <= 8'h00;
        end
        else
        begin
            pin_oe_q  <= ~mode & MASK;
            pin_out_q <= ((alt_en & alt_data) | (~alt_en & latch))
                         & ~mode & MASK;
            // pull-up only on inputs not claimed by a peripheral
            pin_pu_q  <= {8{pu_en}} & mode & ~alt_en & MASK;
        end
    end

endmodule

// >>> test/pin_board.sv
`timescale 1ns/1ps

module pin_board
(
    input  wire logic        aclk,
    input  wire logic [47:0] pin_out,
    input  wire logic [47:0] pin_oe,
    input  wire logic [47:0] pin_pullup,
    input  wire logic [47:0] ext_drv,
    input  wire logic [47:0] ext_en,
    output logic      [47:0] pin_in
);
    logic [47:0] float_q = 48'hAAAAAAAAAAAA;

    // an open pin wanders each cycle so a stale level never looks valid
    always_ff @(posedge aclk)
    begin
        float_q <= ~float_q;
    end

    // own buffer first, then the board driver, then the pull-up
    assign pin_in = (pin_oe & pin_out)
                  | (~pin_oe & ext_en & ext_drv)
                  | (~pin_oe & ~ext_en & pin_pullup)
                  | (~pin_oe & ~ext_en & ~pin_pullup & float_q);
endmodule

// >>> test/tb.sv
`timescale 1ns/1ps
`include "gpio_port_cfg.svh"

module tb;
    import gpio_port_pkg::*;

    localparam logic [17:0] A_DATA = {`PORT_DATA_IDX, 2'b00};
    localparam logic [17:0] A_RMW  = {`PORT_RMW_IDX, 2'b00};
    localparam logic [17:0] A_DIR  = {`PORT_MODE_IDX, 2'b00};
    localparam logic [17:0] A_PU   = {`PULLUP_EN_IDX, 2'b00};
    localparam logic [17:0] A_BIT  = {`PULLUP_BIT_IDX, 2'b00};
    localparam logic [47:0] PINS   = 48'h0FFF0707FFFF;
    localparam axi_resp_t   OK     = `RESP_OKAY;
    localparam axi_resp_t   ERR    = `RESP_SLVERR;

    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [17:0] awaddr = '0;
    logic        awvalid = 1'b0;
    logic        awready;
    logic [31:0] wdata = '0;
    logic [3:0]  wstrb = 4'hF;
    logic        wvalid = 1'b0;
    logic        wready;
    axi_resp_t   bresp;
    logic        bvalid;
    logic        bready = 1'b0;
    logic [17:0] araddr = '0;
    logic        arvalid = 1'b0;
    logic        arready;
    logic [31:0] rdata;
    axi_resp_t   rresp;
    logic        rvalid;
    logic        rready = 1'b0;
    logic [47:0] pin_in;
    logic [47:0] alt_out_en = '0;
    logic [47:0] alt_out_data = '0;
    logic [47:0] pin_out;
    logic [47:0] pin_oe;
    logic [47:0] pin_pullup;
    logic [47:0] ext_drv = '0;
    logic [47:0] ext_en = '0;
    int          err_total = 0;
    int          total_checks = 0;

    always #5 aclk = ~aclk;

    gpio_port_top i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .pin_in(pin_in), .alt_out_en(alt_out_en),
        .alt_out_data(alt_out_data), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup));

    pin_board i_board (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup), .ext_drv(ext_drv), .ext_en(ext_en),
        .pin_in(pin_in));

    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [47:0] seen,
                       input logic [47:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [47:0] pb(input logic [47:0] v, input int m);
        return 48'(v[8*m +: 8]);
    endfunction

    function automatic logic [31:0] cmd(input logic [2:0] p,
        input rmw_op_t op, input logic [2:0] b, input logic [7:0] d);
        return {16'h0000, p, op, b, d};
    endfunction

    // both items offered at once; each valid dropped at its own handshake
    task automatic wr(input logic [17:0] a, input logic [31:0] d,
                      input axi_resp_t e);
        axi_resp_t r;
        r = 2'h3;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        repeat (100)
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            if (bvalid)
            begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
        // idle edge: pads settle, and no signal is set twice at once
        @(posedge aclk);
        chk("bresp", 48'(r), 48'(e));
    endtask

    task automatic rd(input string what, input logic [17:0] a,
                      input logic [7:0] e, input axi_resp_t er);
        logic [31:0] d;
        axi_resp_t   r;
        d = 'x;
        r = 2'h3;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        repeat (100)
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
            if (rvalid)
            begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
        @(posedge aclk);
        chk(what, 48'(d), 48'(e));
        chk("rresp", 48'(r), 48'(er));
    endtask

    task automatic t_reset;
        rd("pu_reg", A_PU, 8'h00, OK);
        for (int m = 0; m < 6; m++)
            rd("dir_reg", A_DIR + 18'(4*m), 8'hFF, OK);
        chk("oe", pin_oe, 48'h0);
        chk("pullup", pin_pullup, 48'h0);
        $display("test reset done");
    endtask

    task automatic t_pullup;
        wr(A_PU, 32'h000000FF, OK);
        rd("pu_reg", A_PU, 8'h3F, OK);
        chk("pullup", pin_pullup, PINS);
        wr(A_BIT, 32'h00000002, OK);
        rd("pu_reg", A_PU, 8'h3B, OK);
        chk("pullup2", pb(pin_pullup, 2), 48'h0);
        wr(A_BIT, 32'h00000102, OK);
        rd("pu_reg", A_PU, 8'h3F, OK);
        $display("test pullup done");
    endtask

    task automatic t_dir;
        wr(A_DIR, 32'h0000000F, OK);
        wr(A_DATA, 32'h000000A5, OK);
        chk("oe0", pb(pin_oe, 0), 48'hF0);
        chk("out0", pb(pin_out, 0), 48'hA0);
        chk("pu0", pb(pin_pullup, 0), 48'h0F);
        ext_drv <= 48'h03;
        ext_en <= 48'h0F;
        repeat (2) @(posedge aclk);
        rd("data0", A_DATA, 8'hA3, OK);
        chk("out0", pb(pin_out, 0), 48'hA0);
        wr(A_DIR, 32'h00000000, OK);
        chk("out0", pb(pin_out, 0), 48'hA5);
        chk("oe0", pb(pin_oe, 0), 48'hFF);
        $display("test direction done");
    endtask

    task automatic t_alt;
        wr(A_DIR, 32'h0000000F, OK);
        alt_out_en <= 48'h81;
        alt_out_data <= 48'h0;
        repeat (2) @(posedge aclk);
        chk("pu0", pb(pin_pullup, 0), 48'h0E);
        chk("out0", pb(pin_out, 0), 48'h20);
        chk("oe0", pb(pin_oe, 0), 48'hF0);
        alt_out_en <= 48'h0;
        repeat (2) @(posedge aclk);
        chk("pu0", pb(pin_pullup, 0), 48'h0F);
        $display("test alternate done");
    endtask

    task automatic t_rmw;
        logic [31:0] c [4];
        logic [7:0]  e [4];
        c = '{cmd(1, OP_BIT_SET, 0, 0), cmd(1, OP_BIT_CLR, 4, 0),
              cmd(1, OP_ADD, 0, 8'h05), cmd(1, OP_XOR, 0, 8'hFF)};
        e = '{8'h11, 8'h01, 8'h06, 8'hF9};
        wr(A_DIR + 18'h4, 32'h0, OK);
        wr(A_DATA + 18'h4, 32'h10, OK);
        for (int i = 0; i < 4; i++)
        begin
            wr(A_RMW, c[i], OK);
            chk("out1", pb(pin_out, 1), 48'(e[i]));
            rd("data1", A_DATA + 18'h4, e[i], OK);
        end
        $display("test rmw done");
    endtask

    // mixed port: the untouched input latches may change, pins may not
    task automatic t_mixed;
        ext_drv <= 48'h0005_0000_0003;
        ext_en <= 48'h000F_0000_000F;
        wr(A_DIR + 18'h10, 32'h0F, OK);
        wr(A_DATA + 18'h10, 32'h00, OK);
        wr(A_RMW, cmd(4, OP_BIT_SET, 7, 0), OK);
        chk("oe4", pb(pin_oe, 4), 48'hF0);
        chk("out4", pb(pin_out, 4), 48'h80);
        chk("pin4", pb(pin_in, 4) & 48'h0F, 48'h05);
        rd("data4", A_DATA + 18'h10, 8'h85, OK);
        $display("test mixed done");
    endtask

    task automatic t_err;
        rd("unmapped", A_DATA + 18'h20, 8'h00, ERR);
        wr(A_DATA + 18'h20, 32'hFF, ERR);
        wr(A_RMW, cmd(6, OP_XOR, 0, 8'hFF), ERR);
        chk("out1", pb(pin_out, 1), 48'hF9);
        // lane 0 not strobed: the write must leave the enables alone
        wstrb <= 4'hE;
        wr(A_PU, 32'h0, OK);
        wstrb <= 4'hF;
        rd("pu_reg", A_PU, 8'h3F, OK);
        $display("test errors done");
    endtask

    // the whole sequence needs fewer than two hundred cycles
    initial
    begin
        repeat (20000) @(posedge aclk);
        err_total++;
        results();
    end

    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_pullup();
        t_dir();
        t_alt();
        t_rmw();
        t_mixed();
        t_err();
        results();
    end
endmodule
